// ---- hdl/mcc_pkg.sv ----
package mcc_pkg;

	// Sizes
	localparam int FLAG_W    = 32;
	localparam int CFG_W     = 32;
	localparam int LANE_W    = 8;
	localparam int MODE_W    = 3;
	localparam int NUM_VA    = 3;
	localparam int NUM_STORE = 10;
	localparam int STORE_AW  = 4;
	localparam int CMD_W     = 4;
	localparam int ARG_W     = 8;
	localparam int SEL_W     = 3;

	// Completion word bit positions
	localparam int FLG_NONHARM_LSB = 0;
	localparam int FLG_MOTOR       = 3;
	localparam int FLG_HARM_LSB    = 8;
	localparam int FLG_SPEC        = 16;

	// Configuration word layout: lane 0 holds the mode, lanes 1..3 the analyzers
	localparam int                 CFG_MODE_LSB    = 0;
	localparam logic [CFG_W-1:0]   CFG_FACTORY_DEF = 32'h0000_0000;

	// Analyzer selector codes; 4 and above are channel groups
	localparam logic [SEL_W-1:0]   SEL_VA_FIRST = 3'h1;
	localparam logic [SEL_W-1:0]   SEL_VA_LAST  = 3'h3;

	// Store indexes
	localparam logic [ARG_W-1:0]   STORE_FACTORY = 8'h00;
	localparam logic [ARG_W-1:0]   STORE_FIRST   = 8'h01;
	localparam logic [ARG_W-1:0]   STORE_LAST    = 8'h0A;

	// Argument limits
	localparam logic [ARG_W-1:0]   SCOPE_ARG_MAX = 8'h02;
	localparam logic [ARG_W-1:0]   STBY_ARG_MAX  = 8'h01;

	// Operating modes
	localparam logic [MODE_W-1:0]  MODE_SINGLE   = 3'h0;
	localparam logic [MODE_W-1:0]  MODE_MULTI    = 3'h1;
	localparam logic [MODE_W-1:0]  MODE_SYNC     = 3'h2;
	localparam logic [MODE_W-1:0]  MODE_HARM_A   = 3'h3;
	localparam logic [MODE_W-1:0]  MODE_HARM_B   = 3'h5;
	localparam logic [MODE_W-1:0]  MODE_SPECTRUM = 3'h7;

	// Scope status codes
	localparam logic [2:0]         SCP_STOP_EMPTY = 3'h0;
	localparam logic [2:0]         SCP_STOP_DATA  = 3'h1;
	localparam logic [2:0]         SCP_SINGLE     = 3'h2;
	localparam logic [2:0]         SCP_CONT_EMPTY = 3'h3;
	localparam logic [2:0]         SCP_CONT_DATA  = 3'h4;

	// Standby state codes
	localparam logic [2:0]         STBY_NEVER    = 3'h0;
	localparam logic [2:0]         STBY_STOPPED  = 3'h1;
	localparam logic [2:0]         STBY_ENDED    = 3'h2;
	localparam logic [2:0]         STBY_WAIT_LVL = 3'h3;
	localparam logic [2:0]         STBY_RUN_MIN  = 3'h4;
	localparam logic [2:0]         STBY_RUN_EXT  = 3'h5;

	// Command codes, in this order from zero
	typedef enum logic [CMD_W-1:0] {
		CMD_FLAGS_Q, CMD_SCOPE, CMD_SCOPE_Q, CMD_STBY_RUN, CMD_STBY_Q,
		CMD_SAVE, CMD_RECALL, CMD_BEGIN_EDIT, CMD_COMMIT, CMD_MODE,
		CMD_STAGE_SET, CMD_RST, CMD_CLS
	} mcc_cmd_t;

	typedef enum logic [1:0] {SCP_RUN_OFF, SCP_RUN_SINGLE, SCP_RUN_CONT} mcc_scope_t;
	typedef enum logic {ST_IDLE, ST_RCL_LOAD} mcc_state_t;

endpackage

// ---- hdl/mcc_store_if.sv ----
`timescale 1ns/100ps
interface mcc_store_if #(
	parameter int AW = 4,
	parameter int DW = 32
);
	logic          wr_en;
	logic          rd_en;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport ctrl (output wr_en, output rd_en, output addr, output wdata, input rdata);
	modport mem  (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface

// ---- hdl/mcc_cfg_store.sv ----
`timescale 1ns/100ps
module mcc_cfg_store import mcc_pkg::*; #(
	parameter int DEPTH = NUM_STORE + 1
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Store port
	mcc_store_if.mem  bus
);

	logic [CFG_W-1:0] mem_r [DEPTH];

	// User stores only; word 0 is never written
	// factory store protected
	always_ff @(posedge i_clk) begin
		if (bus.wr_en && bus.addr != STORE_AW'(STORE_FACTORY) && int'(bus.addr) < DEPTH) begin
			mem_r[bus.addr] <= bus.wdata;
		end
	end

	// Registered read; factory answers from a constant
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus.rdata <= '0;
		end else if (bus.rd_en) begin
			if (bus.addr == STORE_AW'(STORE_FACTORY)) begin
				bus.rdata <= CFG_FACTORY_DEF;
			end else begin
				bus.rdata <= mem_r[bus.addr];
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	factory_read_a: assert property (bus.rd_en && bus.addr == STORE_AW'(STORE_FACTORY) |=> bus.rdata == CFG_FACTORY_DEF)
		else $error("factory store read back altered");

endmodule

// ---- hdl/mcc_cmd_ctrl.sv ----
`timescale 1ns/100ps
module mcc_cmd_ctrl import mcc_pkg::*; (
	// Clock and reset
	input  wire logic                 I_CLK_SYS,
	input  wire logic                 I_RST_N,
	// Command port
	input  wire logic                 I_CMD_VALID,
	input  wire logic [CMD_W-1:0]     I_CMD_CODE,
	input  wire logic [SEL_W-1:0]     I_CMD_SEL,
	input  wire logic [ARG_W-1:0]     I_CMD_ARG,
	output logic                      O_CMD_READY,
	// Response port
	output logic                      O_RSP_VALID,
	output logic                      O_RSP_ERR,
	output logic [FLAG_W-1:0]         O_RSP_DATA,
	// Measurement events
	input  wire logic [NUM_VA-1:0]    I_NONHARM_DONE,
	input  wire logic                 I_MOTOR_DONE,
	input  wire logic [NUM_VA-1:0]    I_HARM_DONE,
	input  wire logic                 I_SPEC_DONE,
	// Hardware status
	input  wire logic                 I_MULTI_CH,
	input  wire logic                 I_DC_ZERO,
	// Scope capture engine
	input  wire logic                 I_SCOPE_CAPTURED,
	output logic [1:0]                O_SCOPE_RUN,
	output logic                      O_SCOPE_CLEAR,
	// Standby engines
	input  wire logic [NUM_VA-1:0]    I_STBY_LEVEL,
	input  wire logic [NUM_VA-1:0]    I_STBY_MIN,
	input  wire logic [NUM_VA-1:0]    I_STBY_END,
	output logic [NUM_VA-1:0]         O_STBY_RUN,
	// Active configuration
	output logic [CFG_W-1:0]          O_ACTIVE_CFG,
	output logic                      O_MEAS_RESTART
);

	// Selector is one analyzer, not a channel group
	function automatic logic sel_is_va(input logic [SEL_W-1:0] sel);
		return sel >= SEL_VA_FIRST && sel <= SEL_VA_LAST;
	endfunction

	function automatic logic [1:0] va_index(input logic [SEL_W-1:0] sel);
		return 2'(sel - SEL_VA_FIRST);
	endfunction

	function automatic logic mode_needs_multi(input logic [MODE_W-1:0] m);
		return m == MODE_MULTI || m == MODE_SYNC;
	endfunction

	function automatic logic stby_running(input logic [2:0] s);
		return s == STBY_WAIT_LVL || s == STBY_RUN_MIN || s == STBY_RUN_EXT;
	endfunction

	mcc_state_t       state_r;
	mcc_cmd_t         code;
	mcc_scope_t       scope_run_r;
	logic             scope_data_r;
	logic [FLAG_W-1:0] flags_r;
	logic [FLAG_W-1:0] flags_nxt;
	logic [FLAG_W-1:0] flag_set;
	logic [CFG_W-1:0] active_r;
	logic [CFG_W-1:0] staged_r;
	logic [15:0]      saved_r;
	logic [2:0]       stby_r   [NUM_VA];
	logic [2:0]       stby_nxt [NUM_VA];
	logic [2:0]       scope_code;
	logic [FLAG_W-1:0] rsp_nxt;
	logic             cmd_err;
	logic             go;
	logic             ok;
	logic             staging;
	logic             commit_ok;
	logic             cfg_changed;
	logic             flags_clear;
	logic [MODE_W-1:0] staged_mode;

	mcc_store_if #(.AW(STORE_AW), .DW(CFG_W)) store_bus ();

	mcc_cfg_store mcc_cfg_store_i (
		.i_clk   (I_CLK_SYS),
		.i_rst_n (I_RST_N),
		.bus     (store_bus.mem)
	);

	assign code        = mcc_cmd_t'(I_CMD_CODE);
	assign go          = I_CMD_VALID && O_CMD_READY;
	assign ok          = go && !cmd_err;
	assign staged_mode = staged_r[CFG_MODE_LSB +: MODE_W];
	assign cfg_changed = staged_r != active_r;
	assign commit_ok   = ok && code == CMD_COMMIT;
	assign staging     = code == CMD_MODE || code == CMD_STAGE_SET;

	// Scope status code from run mode and data presence
	// scope status encoding
	always_comb begin
		case (scope_run_r)
			SCP_RUN_SINGLE: scope_code = SCP_SINGLE;
			SCP_RUN_CONT:   scope_code = scope_data_r ? SCP_CONT_DATA : SCP_CONT_EMPTY;
			default:        scope_code = scope_data_r ? SCP_STOP_DATA : SCP_STOP_EMPTY;
		endcase
	end

	// Command check and query answer
	always_comb begin
		cmd_err = 1'b0;
		rsp_nxt = '0;
		case (code)
			CMD_FLAGS_Q: rsp_nxt = flags_r;
			CMD_SCOPE:   cmd_err = I_CMD_ARG > SCOPE_ARG_MAX;
			CMD_SCOPE_Q: rsp_nxt = FLAG_W'(scope_code);
			CMD_STBY_RUN: cmd_err = !sel_is_va(I_CMD_SEL) || I_CMD_ARG > STBY_ARG_MAX;
			CMD_STBY_Q: begin
				cmd_err = !sel_is_va(I_CMD_SEL);
				rsp_nxt = cmd_err ? '0 : FLAG_W'(stby_r[va_index(I_CMD_SEL)]);
			end
			CMD_SAVE:   cmd_err = I_CMD_ARG < STORE_FIRST || I_CMD_ARG > STORE_LAST;
			CMD_RECALL: cmd_err = I_CMD_ARG > STORE_LAST || !saved_r[I_CMD_ARG[3:0]];
			CMD_BEGIN_EDIT, CMD_RST, CMD_CLS: cmd_err = 1'b0;
			CMD_COMMIT: cmd_err = mode_needs_multi(staged_mode) && !I_MULTI_CH;
			CMD_MODE: cmd_err = I_CMD_ARG > ARG_W'(MODE_SPECTRUM) || I_CMD_ARG == 8'h04 || I_CMD_ARG == 8'h06;
			CMD_STAGE_SET: cmd_err = !sel_is_va(I_CMD_SEL);
			default: cmd_err = 1'b1;
		endcase
		if ((staging || code == CMD_COMMIT) && I_DC_ZERO) begin
			cmd_err = 1'b1;
		end
	end

	// Ready and recall sequencing; recall waits one cycle for store data
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_r     <= ST_IDLE;
			O_CMD_READY <= 1'b1;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (ok && code == CMD_RECALL) begin
						state_r     <= ST_RCL_LOAD;
						O_CMD_READY <= 1'b0;
					end
				end
				default: begin
					state_r     <= ST_IDLE;
					O_CMD_READY <= 1'b1;
				end
			endcase
		end
	end

	// Store port driven straight from the taken command
	// save active config
	assign store_bus.wr_en = ok && code == CMD_SAVE;
	assign store_bus.rd_en = ok && code == CMD_RECALL;
	assign store_bus.addr  = I_CMD_ARG[STORE_AW-1:0];
	assign store_bus.wdata = active_r;

	// Saved markers; factory always loadable
	// ten user stores tracked
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			saved_r <= 16'h0001;
		end else if (store_bus.wr_en) begin
			saved_r[I_CMD_ARG[3:0]] <= 1'b1;
		end
	end

	// Response register
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_RSP_VALID <= 1'b0;
			O_RSP_ERR   <= 1'b0;
			O_RSP_DATA  <= '0;
		end else begin
			O_RSP_VALID <= (go && !(ok && code == CMD_RECALL)) || state_r == ST_RCL_LOAD;
			O_RSP_ERR   <= go && cmd_err;
			O_RSP_DATA  <= ok ? rsp_nxt : '0;
		end
	end

	// Completion events gathered into the flag word
	// non-harmonic, motor, harmonic and spectrum bits
	assign flag_set = (FLAG_W'(I_NONHARM_DONE) << FLG_NONHARM_LSB)
		| (FLAG_W'(I_MOTOR_DONE) << FLG_MOTOR)
		| (FLAG_W'(I_HARM_DONE) << FLG_HARM_LSB)
		| (FLAG_W'(I_SPEC_DONE) << FLG_SPEC);

	assign flags_clear = (ok && code == CMD_FLAGS_Q) || (commit_ok && cfg_changed);
	// Set wins over clear so no completion is lost
	assign flags_nxt   = (flags_clear ? '0 : flags_r) | flag_set;

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// Active configuration and restart strobe
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			active_r       <= CFG_FACTORY_DEF;
			O_MEAS_RESTART <= 1'b0;
		end else begin
			O_MEAS_RESTART <= 1'b0;
			if (commit_ok) begin
				active_r       <= staged_r;
				O_MEAS_RESTART <= cfg_changed;
			end else if (state_r == ST_RCL_LOAD) begin
				active_r       <= store_bus.rdata;
				O_MEAS_RESTART <= 1'b1;
			end
		end
	end

	assign O_ACTIVE_CFG = active_r;

	// Staged configuration, only applied by commit
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			staged_r <= CFG_FACTORY_DEF;
		end else if (state_r == ST_RCL_LOAD) begin
			staged_r <= store_bus.rdata;
		end else if (ok) begin
			case (code)
				CMD_MODE:      staged_r[CFG_MODE_LSB +: MODE_W] <= I_CMD_ARG[MODE_W-1:0];
				CMD_STAGE_SET: staged_r[LANE_W*int'(I_CMD_SEL) +: LANE_W] <= I_CMD_ARG;
				CMD_BEGIN_EDIT: staged_r <= active_r;
				CMD_RST, CMD_CLS: staged_r <= active_r;
				default: staged_r <= staged_r;
			endcase
		end
	end

	// Scope capture control
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			scope_run_r   <= SCP_RUN_OFF;
			scope_data_r  <= 1'b0;
			O_SCOPE_CLEAR <= 1'b0;
		end else begin
			O_SCOPE_CLEAR <= 1'b0;
			if (ok && code == CMD_SCOPE) begin
				scope_run_r <= mcc_scope_t'(I_CMD_ARG[1:0]);
				if (I_CMD_ARG != 8'h00) begin
					scope_data_r  <= 1'b0;
					O_SCOPE_CLEAR <= 1'b1;
				end
			end else if (I_SCOPE_CAPTURED && scope_run_r != SCP_RUN_OFF) begin
				scope_data_r <= 1'b1;
				// Single capture ends with its first view
				if (scope_run_r == SCP_RUN_SINGLE) begin
					scope_run_r <= SCP_RUN_OFF;
				end
			end
		end
	end

	// Mirror of the run mode for the capture engine
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_SCOPE_RUN <= 2'h0;
		end else if (ok && code == CMD_SCOPE) begin
			O_SCOPE_RUN <= I_CMD_ARG[1:0];
		end else if (I_SCOPE_CAPTURED && scope_run_r == SCP_RUN_SINGLE) begin
			O_SCOPE_RUN <= 2'h0;
		end
	end

	// Standby state per analyzer; operator command beats engine events
	always_comb begin
		for (int v = 0; v < NUM_VA; v++) begin
			stby_nxt[v] = stby_r[v];
			case (stby_r[v])
				STBY_WAIT_LVL: if (I_STBY_LEVEL[v]) stby_nxt[v] = STBY_RUN_MIN;
				STBY_RUN_MIN: begin
					if (I_STBY_END[v]) begin
						stby_nxt[v] = STBY_ENDED;
					end else if (I_STBY_MIN[v]) begin
						stby_nxt[v] = STBY_RUN_EXT;
					end
				end
				STBY_RUN_EXT: if (I_STBY_END[v]) stby_nxt[v] = STBY_ENDED;
				default: stby_nxt[v] = stby_r[v];
			endcase
			if (ok && code == CMD_STBY_RUN && va_index(I_CMD_SEL) == 2'(v)) begin
				if (I_CMD_ARG[0]) begin
					stby_nxt[v] = STBY_WAIT_LVL;
				end else if (stby_running(stby_r[v])) begin
					stby_nxt[v] = STBY_STOPPED;
				end
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			for (int v = 0; v < NUM_VA; v++) begin
				stby_r[v] <= STBY_NEVER;
			end
			O_STBY_RUN <= '0;
		end else begin
			for (int v = 0; v < NUM_VA; v++) begin
				stby_r[v]     <= stby_nxt[v];
				O_STBY_RUN[v] <= stby_running(stby_nxt[v]);
			end
		end
	end

	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);

	flags_read_a: assert property (ok && code == CMD_FLAGS_Q |=> O_RSP_VALID && O_RSP_DATA == $past(flags_r) && flags_r == $past(flag_set))
		else $error("flag query did not return and clear word");
	nonharm_set_a: assert property (|I_NONHARM_DONE |=> (flags_r[FLG_NONHARM_LSB +: NUM_VA] & $past(I_NONHARM_DONE)) == $past(I_NONHARM_DONE))
		else $error("non-harmonic completion lost");
	motor_set_a: assert property (I_MOTOR_DONE |=> flags_r[FLG_MOTOR])
		else $error("motor completion lost");
	harm_set_a: assert property (|I_HARM_DONE |=> (flags_r[FLG_HARM_LSB +: NUM_VA] & $past(I_HARM_DONE)) == $past(I_HARM_DONE))
		else $error("harmonic completion lost");
	spec_set_a: assert property (I_SPEC_DONE |=> flags_r[FLG_SPEC])
		else $error("spectrum completion lost");
	commit_clear_a: assert property (commit_ok && cfg_changed && flag_set == '0 |=> flags_r == '0 && O_MEAS_RESTART)
		else $error("commit with change kept flags");
	scope_start_a: assert property (ok && code == CMD_SCOPE && I_CMD_ARG != 8'h00 |=> O_SCOPE_CLEAR && !scope_data_r)
		else $error("scope start kept old data");
	scope_code_a: assert property (ok && code == CMD_SCOPE_Q |=> O_RSP_DATA <= FLAG_W'(SCP_CONT_DATA))
		else $error("scope status out of range");
	stby_start_a: assert property (ok && code == CMD_STBY_RUN && I_CMD_ARG[0] |=> O_STBY_RUN[$past(va_index(I_CMD_SEL))])
		else $error("standby did not start");
	group_sel_a: assert property (go && staging && !sel_is_va(I_CMD_SEL) && code == CMD_STAGE_SET |=> O_RSP_ERR && $stable(staged_r))
		else $error("channel group selector accepted");
	edit_reload_a: assert property (ok && code == CMD_BEGIN_EDIT |=> staged_r == $past(active_r))
		else $error("begin edit did not reload staging");
	reject_hold_a: assert property (go && cmd_err |=> O_RSP_ERR && $stable(active_r) && $stable(staged_r) ##1 ($stable(active_r) || $past(go)))
		else $error("rejected command changed configuration");

endmodule

// ---- verif/mcc_ctl_model.sv ----
`timescale 1ns/100ps
module mcc_ctl_model import mcc_pkg::*; (
	// Clock and handshake
	input  wire logic             i_clk,
	input  wire logic             i_ready,
	input  wire logic             i_dc_zero,
	// Command lines
	output logic                  o_valid,
	output logic [CMD_W-1:0]      o_code,
	output logic [SEL_W-1:0]      o_sel,
	output logic [ARG_W-1:0]      o_arg
);
	// Idle lines at time zero
	initial begin
		o_valid = 1'b0;
		o_code  = '0;
		o_sel   = '0;
		o_arg   = '0;
	end

	// Offer one command after an idle gap and hold it until taken
	task automatic send(input logic [CMD_W-1:0] code, input logic [SEL_W-1:0] sel,
		input logic [ARG_W-1:0] arg, input bit rude, input int gap, output bit ok);
		int n;
		ok = 1'b0;
		repeat (gap) begin
			@(posedge i_clk);
			#1;
		end
		for (n = 0; n < 64 && !rude && i_dc_zero && code >= CMD_BEGIN_EDIT && code <= CMD_STAGE_SET; n++) begin
			@(posedge i_clk);
			#1;
		end
		// Zeroing never ended: send nothing, caller counts the miss
		if (n == 64) return;
		o_valid = 1'b1;
		o_code  = code;
		o_sel   = sel;
		o_arg   = arg;
		// Ready is a register, so look at it before the edge that takes
		for (n = 0; n < 64 && !ok; n++) begin
			ok = i_ready;
			@(posedge i_clk);
			#1;
		end
		// Released lines show the inverse, never a stale copy
		o_valid = 1'b0;
		o_code  = ~code;
		o_sel   = ~sel;
		o_arg   = ~arg;
	endtask
endmodule

// ---- verif/measurement_command_control_bench.sv ----
`timescale 1ns/100ps
module measurement_command_control_bench import mcc_pkg::*;;
	logic                clk_sys, rst_n, multi_ch, dc_zero;
	logic                cmd_valid, cmd_ready, rsp_valid, rsp_err, scope_clear, meas_restart;
	logic [CMD_W-1:0]    cmd_code;
	logic [SEL_W-1:0]    cmd_sel;
	logic [ARG_W-1:0]    cmd_arg, r, r2;
	logic [FLAG_W-1:0]   rsp_data, active_cfg, exp_cfg;
	logic [1:0]          scope_run;
	logic [NUM_VA-1:0]   stby_run;
	logic [17:0]         ev, v;
	logic [32:0]         exp_q[$];
	logic [CMD_W-1:0]    dis[3];
	int                  n_fail, checked, n_clr, n_rs, n_busy, i;
	bit                  bad;

	// Clock, half period of 4 ns
	initial clk_sys = 1'b0;
	always #4 clk_sys = ~clk_sys;

	mcc_cmd_ctrl mcc_cmd_ctrl_i (
		.I_CLK_SYS(clk_sys), .I_RST_N(rst_n),
		.I_CMD_VALID(cmd_valid), .I_CMD_CODE(cmd_code), .I_CMD_SEL(cmd_sel), .I_CMD_ARG(cmd_arg),
		.O_CMD_READY(cmd_ready), .O_RSP_VALID(rsp_valid), .O_RSP_ERR(rsp_err), .O_RSP_DATA(rsp_data),
		.I_NONHARM_DONE(ev[2:0]), .I_MOTOR_DONE(ev[3]), .I_HARM_DONE(ev[6:4]), .I_SPEC_DONE(ev[7]),
		.I_MULTI_CH(multi_ch), .I_DC_ZERO(dc_zero), .I_SCOPE_CAPTURED(ev[8]),
		.O_SCOPE_RUN(scope_run), .O_SCOPE_CLEAR(scope_clear),
		.I_STBY_LEVEL(ev[11:9]), .I_STBY_MIN(ev[14:12]), .I_STBY_END(ev[17:15]),
		.O_STBY_RUN(stby_run), .O_ACTIVE_CFG(active_cfg), .O_MEAS_RESTART(meas_restart));

	mcc_ctl_model mcc_ctl_model_i (
		.i_clk(clk_sys), .i_ready(cmd_ready), .i_dc_zero(dc_zero),
		.o_valid(cmd_valid), .o_code(cmd_code), .o_sel(cmd_sel), .o_arg(cmd_arg));

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_fail++;
		end
		checked++;
	endtask

	task automatic end_of_test();
		if (n_fail == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Event pulses last exactly one cycle
	task automatic pulse(input logic [17:0] pv);
		ev = pv;
		tick();
		ev = '0;
	endtask

	// Note the expected answer, send, then wait a bounded time for it
	task automatic cmd(input logic [CMD_W-1:0] c, input logic [SEL_W-1:0] s, input logic [ARG_W-1:0] a,
		input logic e, input logic [FLAG_W-1:0] d, input bit rude = 1'b0);
		bit ok;
		int n;
		exp_q.push_back({e, d});
		mcc_ctl_model_i.send(c, s, a, rude, $urandom % 3, ok);
		for (n = 0; n < 16 && exp_q.size() != 0; n++) tick();
		if (!ok || exp_q.size() != 0) begin
			n_fail++;
			end_of_test();
		end
	endtask

	function automatic logic [31:0] flag_of(input logic [17:0] fv);
		return {15'h0, fv[7], 5'h0, fv[6:4], 4'h0, fv[3], fv[2:0]};
	endfunction

	// Answer watcher: each pulse consumes the oldest note
	always @(posedge clk_sys) begin
		if (rsp_valid === 1'b1) begin
			if (exp_q.size() == 0) chk({rsp_err, rsp_data}, 'x);
			else chk({rsp_err, rsp_data}, exp_q.pop_front());
		end
		if (scope_clear === 1'b1) n_clr++;
		// Restart pulses and busy cycles, checked after commits and recalls
		if (meas_restart === 1'b1) n_rs++;
		if (cmd_ready === 1'b0) n_busy++;
	end

	initial begin
		rst_n    = 1'b0;
		multi_ch = 1'b0;
		dc_zero  = 1'b0;
		ev       = '0;
		n_fail   = 0;
		checked  = 0;
		n_clr    = 0;
		n_rs     = 0;
		n_busy   = 0;
		dis      = '{CMD_BEGIN_EDIT, CMD_RST, CMD_CLS};
		void'($urandom(32'hBE58));
		repeat (16) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		chk(33'(cmd_ready), 33'h1);
		chk(33'(active_cfg), 33'h0);
		// Completion word: every bit once, then random mixes
		for (i = 0; i < 4; i++) begin
			v = (i == 0) ? 18'hFF : {10'h0, 8'($urandom)};
			pulse(v);
			cmd(CMD_FLAGS_Q, 3'h0, 8'h00, 1'b0, flag_of(v));
			cmd(CMD_FLAGS_Q, 3'h0, 8'h00, 1'b0, 32'h0);
		end
		// Scope capture codes and discard on start
		cmd(CMD_SCOPE, 3'h0, 8'h01, 1'b0, 32'h0);
		chk(33'(n_clr), 33'h1);
		cmd(CMD_SCOPE_Q, 3'h0, 8'h00, 1'b0, 32'(SCP_SINGLE));
		pulse(18'h100);
		cmd(CMD_SCOPE_Q, 3'h0, 8'h00, 1'b0, 32'(SCP_STOP_DATA));
		chk(33'(scope_run), 33'h0);
		cmd(CMD_SCOPE, 3'h0, 8'h02, 1'b0, 32'h0);
		cmd(CMD_SCOPE_Q, 3'h0, 8'h00, 1'b0, 32'(SCP_CONT_EMPTY));
		pulse(18'h100);
		cmd(CMD_SCOPE_Q, 3'h0, 8'h00, 1'b0, 32'(SCP_CONT_DATA));
		chk(33'(scope_run), 33'h2);
		cmd(CMD_SCOPE, 3'h0, 8'h03, 1'b1, 32'h0);
		cmd(CMD_SCOPE, 3'h0, 8'h01, 1'b0, 32'h0);
		cmd(CMD_SCOPE, 3'h0, 8'h00, 1'b0, 32'h0);
		cmd(CMD_SCOPE_Q, 3'h0, 8'h00, 1'b0, 32'(SCP_STOP_EMPTY));
		chk(33'(n_clr), 33'h3);
		// Standby state walk on each analyzer
		for (i = 1; i <= 3; i++) begin
			cmd(CMD_STBY_Q, 3'(i), 8'h00, 1'b0, 32'(STBY_NEVER));
			cmd(CMD_STBY_RUN, 3'(i), 8'h01, 1'b0, 32'h0);
			cmd(CMD_STBY_Q, 3'(i), 8'h00, 1'b0, 32'(STBY_WAIT_LVL));
			chk(33'(stby_run), 33'(1 << (i - 1)));
			pulse(18'h200 << (i - 1));
			cmd(CMD_STBY_Q, 3'(i), 8'h00, 1'b0, 32'(STBY_RUN_MIN));
			pulse(18'h1000 << (i - 1));
			cmd(CMD_STBY_Q, 3'(i), 8'h00, 1'b0, 32'(STBY_RUN_EXT));
			pulse(18'h8000 << (i - 1));
			cmd(CMD_STBY_Q, 3'(i), 8'h00, 1'b0, 32'(STBY_ENDED));
			cmd(CMD_STBY_RUN, 3'(i), 8'h01, 1'b0, 32'h0);
			cmd(CMD_STBY_RUN, 3'(i), 8'h00, 1'b0, 32'h0);
			cmd(CMD_STBY_Q, 3'(i), 8'h00, 1'b0, 32'(STBY_STOPPED));
			chk(33'(stby_run), 33'h0);
		end
		cmd(CMD_STBY_RUN, 3'h4, 8'h01, 1'b1, 32'h0);
		cmd(CMD_STBY_RUN, 3'h1, 8'h02, 1'b1, 32'h0);
		// Every mode code staged and committed
		multi_ch = 1'b1;
		for (i = 0; i < 9; i++) begin
			bad = (i == 4 || i == 6 || i == 8);
			cmd(CMD_MODE, 3'h0, 8'(i), bad, 32'h0);
			if (!bad) begin
				pulse(18'h1);
				cmd(CMD_COMMIT, 3'h0, 8'h00, 1'b0, 32'h0);
				chk(33'(active_cfg[2:0]), 33'(i));
				cmd(CMD_FLAGS_Q, 3'h0, 8'h00, 1'b0, (i == 0) ? 32'h1 : 32'h0);
			end
		end
		chk(33'(n_rs), 33'h5);
		// Staged lanes, selector refusal, stores
		r  = 8'($urandom);
		r2 = 8'($urandom);
		cmd(CMD_STAGE_SET, 3'h2, r, 1'b0, 32'h0);
		cmd(CMD_STAGE_SET, 3'h5, r2, 1'b1, 32'h0);
		cmd(CMD_STAGE_SET, 3'h0, r2, 1'b1, 32'h0);
		cmd(CMD_COMMIT, 3'h0, 8'h00, 1'b0, 32'h0);
		exp_cfg = {8'h00, r, 8'h00, 8'h07};
		chk(33'(active_cfg), 33'(exp_cfg));
		cmd(CMD_SAVE, 3'h0, 8'h03, 1'b0, 32'h0);
		cmd(CMD_STAGE_SET, 3'h1, r2, 1'b0, 32'h0);
		cmd(CMD_COMMIT, 3'h0, 8'h00, 1'b0, 32'h0);
		cmd(CMD_SAVE, 3'h0, 8'h0A, 1'b0, 32'h0);
		cmd(CMD_SAVE, 3'h0, 8'h00, 1'b1, 32'h0);
		cmd(CMD_SAVE, 3'h0, 8'h0B, 1'b1, 32'h0);
		cmd(CMD_RECALL, 3'h0, 8'h04, 1'b1, 32'h0);
		cmd(CMD_RECALL, 3'h0, 8'h0B, 1'b1, 32'h0);
		n_rs   = 0;
		n_busy = 0;
		cmd(CMD_RECALL, 3'h0, 8'h00, 1'b0, 32'h0);
		chk(33'(active_cfg), 33'(CFG_FACTORY_DEF));
		cmd(CMD_RECALL, 3'h0, 8'h03, 1'b0, 32'h0);
		chk(33'(active_cfg), 33'(exp_cfg));
		cmd(CMD_RECALL, 3'h0, 8'h0A, 1'b0, 32'h0);
		exp_cfg = {8'h00, r, r2, 8'h07};
		chk(33'(active_cfg), 33'(exp_cfg));
		chk(33'(n_rs), 33'h3);
		chk(33'(n_busy), 33'h3);
		// Pending changes dropped by begin-edit, reset and clear-status
		for (i = 0; i < 3; i++) begin
			cmd(CMD_MODE, 3'h0, 8'h03, 1'b0, 32'h0);
			cmd(dis[i], 3'h0, 8'h00, 1'b0, 32'h0);
			cmd(CMD_COMMIT, 3'h0, 8'h00, 1'b0, 32'h0);
			chk(33'(active_cfg), 33'(exp_cfg));
		end
		chk(33'(n_rs), 33'h3);
		// Multi-analyzer mode with one channel, and zeroing refusals
		multi_ch = 1'b0;
		cmd(CMD_MODE, 3'h0, 8'h01, 1'b0, 32'h0);
		cmd(CMD_COMMIT, 3'h0, 8'h00, 1'b1, 32'h0);
		chk(33'(active_cfg), 33'(exp_cfg));
		dc_zero = 1'b1;
		cmd(CMD_MODE, 3'h0, 8'h00, 1'b1, 32'h0, 1'b1);
		cmd(CMD_COMMIT, 3'h0, 8'h00, 1'b1, 32'h0, 1'b1);
		cmd(CMD_BEGIN_EDIT, 3'h0, 8'h00, 1'b0, 32'h0, 1'b1);
		dc_zero = 1'b0;
		for (i = 13; i < 16; i++) cmd(4'(i), 3'h0, 8'h00, 1'b1, 32'h0);
		chk(33'(n_rs), 33'h3);
		end_of_test();
	end
endmodule
